/* rtl/wosb_bank.sv */
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "wosb_defines.svh"

// Functional notes
// R01: keep readable copies of write-only register values for read-modify-write.
// R02: index 80h returns last byte written to first dma request register.
// R03: index 81h returns last byte written to first dma single mask register.
// R04: index 82h returns last byte written to first dma mode register.
// R05: index 83h returns last byte written to first dma byte-pointer clear.
// R06: index 84h returns last byte written to first dma master clear.
// R07: index 85h returns last byte written to first dma clear-all-masks.
// R08: index 86h returns last byte written to timer 1 command/mode register.
// R09: index 87h combines last nmi mask value and last accessed cmos address.
// R10: index 88h returns last byte written to second dma request register.
// R11: index 89h returns last byte written to second dma single mask register.
// R12: index 8Ah returns last byte written to second dma mode register.
// R13: index 8Bh returns last byte written to second dma byte-pointer clear.
// R14: index 8Ch returns last byte written to second dma mask clear register.
// R15: index 8Dh returns last byte written to second dma clear register.
// R16: index 8Eh returns last byte written to coprocessor error register.
// R17: index 8Fh returns last byte written to extended cmos address register.
// R18: shadow updates with the write-only register write; direct writes touch copy only.
module wosb_bank
  import wosb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wo_write_valid,
  input wire logic [3:0] wo_write_slot,
  input wire logic [7:0] wo_write_data,
  input wire logic cmos_access_valid,
  input wire logic [6:0] cmos_access_addr
);

  localparam int SLOTS = `WOSB_SLOT_COUNT;

  wosb_state_t state;
  wosb_byte_t shadow [SLOTS];
  logic [SLOTS-1:0] snoop_enable;
  logic [SLOTS-1:0] update_flags;
  logic [SLOTS-1:0] hw_hit;
  logic [SLOTS-1:0] sw_hit;
  logic [SLOTS-1:0] next_flags;
  logic req_access;
  logic commit;
  logic wr_commit;
  logic addr_in_bank;
  logic addr_is_enable;
  logic addr_is_flags;
  logic addr_mapped;
  wosb_slot_t addr_slot;
  logic [31:0] next_rdata;
  logic [31:0] next_prdata;
  logic next_ready;
  logic next_err;
  wosb_byte_t next_shadow [SLOTS];

  // bits above the index field must be clear, else the word aliases higher space
  function automatic logic wosb_high_clear(input logic [ADDR_W-1:0] a);
    logic hi_zero;
    hi_zero = 1'b1;
    for (int i = `WOSB_IDX_MSB + 1; i < ADDR_W; i++) begin
      if (a[i]) begin
        hi_zero = 1'b0;
      end
    end
    return hi_zero;
  endfunction : wosb_high_clear

  // index match; upper bits must be zero so aliases stay unmapped
  function automatic logic wosb_is_index(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return wosb_high_clear(a) && (a[1:0] == 2'b00) && (a[`WOSB_IDX_MSB:`WOSB_IDX_LSB] == idx);
  endfunction : wosb_is_index

  // slot of an index inside the bank
  function automatic wosb_slot_t wosb_slot_of(input logic [7:0] idx);
    return idx[3:0];
  endfunction : wosb_slot_of

  function automatic logic wosb_in_bank(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = {`WOSB_BANK_NIBBLE, a[`WOSB_IDX_LSB+3:`WOSB_IDX_LSB]};
    return wosb_is_index(a, idx);
  endfunction : wosb_in_bank

  // slot numbers of the documented copies
  localparam wosb_slot_t SLOT_FIRST_DMA_REQ = wosb_slot_of(`WOSB_IDX_FIRST_DMA_REQ);
  localparam wosb_slot_t SLOT_FIRST_DMA_MASK = wosb_slot_of(`WOSB_IDX_FIRST_DMA_MASK);
  localparam wosb_slot_t SLOT_FIRST_DMA_MODE = wosb_slot_of(`WOSB_IDX_FIRST_DMA_MODE);
  localparam wosb_slot_t SLOT_FIRST_DMA_BPTR = wosb_slot_of(`WOSB_IDX_FIRST_DMA_BPTR);
  localparam wosb_slot_t SLOT_FIRST_DMA_MCLR = wosb_slot_of(`WOSB_IDX_FIRST_DMA_MCLR);
  localparam wosb_slot_t SLOT_FIRST_DMA_MSKCLR = wosb_slot_of(`WOSB_IDX_FIRST_DMA_MSKCLR);
  localparam wosb_slot_t SLOT_TIMER_CMD = wosb_slot_of(`WOSB_IDX_TIMER_CMD);
  localparam wosb_slot_t SLOT_CMOS_NMI = wosb_slot_of(`WOSB_IDX_CMOS_NMI);
  localparam wosb_slot_t SLOT_SECOND_DMA_REQ = wosb_slot_of(`WOSB_IDX_SECOND_DMA_REQ);
  localparam wosb_slot_t SLOT_SECOND_DMA_MASK = wosb_slot_of(`WOSB_IDX_SECOND_DMA_MASK);
  localparam wosb_slot_t SLOT_SECOND_DMA_MODE = wosb_slot_of(`WOSB_IDX_SECOND_DMA_MODE);
  localparam wosb_slot_t SLOT_SECOND_DMA_BPTR = wosb_slot_of(`WOSB_IDX_SECOND_DMA_BPTR);
  localparam wosb_slot_t SLOT_SECOND_DMA_MSKCLR = wosb_slot_of(`WOSB_IDX_SECOND_DMA_MSKCLR);
  localparam wosb_slot_t SLOT_SECOND_DMA_CLR = wosb_slot_of(`WOSB_IDX_SECOND_DMA_CLR);
  localparam wosb_slot_t SLOT_COPROC_ERR = wosb_slot_of(`WOSB_IDX_COPROC_ERR);
  localparam wosb_slot_t SLOT_EXT_CMOS_ADDR = wosb_slot_of(`WOSB_IDX_EXT_CMOS_ADDR);

  assign addr_in_bank = wosb_in_bank(paddr);
  assign addr_is_enable = wosb_is_index(paddr, `WOSB_IDX_SNOOP_ENABLE);
  assign addr_is_flags = wosb_is_index(paddr, `WOSB_IDX_UPDATE_FLAGS);
  assign addr_mapped = addr_in_bank || addr_is_enable || addr_is_flags;
  assign addr_slot = paddr[`WOSB_IDX_LSB+3:`WOSB_IDX_LSB];

  // first access cycle is taken, the answer follows one edge later
  assign req_access = psel && penable && !pready;
  assign commit = psel && penable && pready;
  assign wr_commit = commit && pwrite && addr_mapped;

  // read mux, one copy per documented index
  always_comb begin
    next_rdata = `WOSB_ZERO_WORD;
    if (addr_in_bank) begin
      case (addr_slot)
        SLOT_FIRST_DMA_REQ: begin
          next_rdata[7:0] = shadow[addr_slot]; // R02
        end
        SLOT_FIRST_DMA_MASK: begin
          next_rdata[7:0] = shadow[addr_slot]; // R03
        end
        SLOT_FIRST_DMA_MODE: begin
          next_rdata[7:0] = shadow[addr_slot]; // R04
        end
        SLOT_FIRST_DMA_BPTR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R05
        end
        SLOT_FIRST_DMA_MCLR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R06
        end
        SLOT_FIRST_DMA_MSKCLR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R07
        end
        SLOT_TIMER_CMD: begin
          next_rdata[7:0] = shadow[addr_slot]; // R08
        end
        SLOT_CMOS_NMI: begin
          next_rdata[7:0] = shadow[addr_slot]; // R09
        end
        SLOT_SECOND_DMA_REQ: begin
          next_rdata[7:0] = shadow[addr_slot]; // R10
        end
        SLOT_SECOND_DMA_MASK: begin
          next_rdata[7:0] = shadow[addr_slot]; // R11
        end
        SLOT_SECOND_DMA_MODE: begin
          next_rdata[7:0] = shadow[addr_slot]; // R12
        end
        SLOT_SECOND_DMA_BPTR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R13
        end
        SLOT_SECOND_DMA_MSKCLR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R14
        end
        SLOT_SECOND_DMA_CLR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R15
        end
        SLOT_COPROC_ERR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R16
        end
        SLOT_EXT_CMOS_ADDR: begin
          next_rdata[7:0] = shadow[addr_slot]; // R17
        end
        default: begin
          next_rdata = `WOSB_ZERO_WORD;
        end
      endcase
    end else if (addr_is_enable) begin
      next_rdata[SLOTS-1:0] = snoop_enable;
    end else if (addr_is_flags) begin
      next_rdata[SLOTS-1:0] = update_flags;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WOSB_ST_IDLE;
    end else begin
      case (state)
        WOSB_ST_IDLE: begin
          if (req_access) begin
            state <= WOSB_ST_DONE;
          end
        end
        WOSB_ST_DONE: begin
          state <= WOSB_ST_IDLE;
        end
        default: begin
          state <= WOSB_ST_IDLE;
        end
      endcase
    end
  end

  // answer only from idle; an access held on past pready is answered again every second cycle
  always_comb begin
    next_ready = 1'b0;
    if ((state == WOSB_ST_IDLE) && req_access) begin
      next_ready = 1'b1;
    end
  end

  // registered answer keeps every bus output on a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= next_ready;
    end
  end

  // captured at the first access edge; a snoop in the answer cycle is missed
  always_comb begin
    next_prdata = prdata;
    if (req_access && !pwrite) begin
      next_prdata = next_rdata;
    end else if (commit) begin
      next_prdata = `WOSB_ZERO_WORD;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= `WOSB_ZERO_WORD;
    end else begin
      prdata <= next_prdata;
    end
  end

  always_comb begin
    next_err = pslverr;
    if (req_access) begin
      next_err = !addr_mapped;
    end else if (commit) begin
      next_err = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_err;
    end
  end

  // hardware snoop and software write hits per slot
  generate
    for (genvar s = 0; s < SLOTS; s++) begin : g_hit
      assign hw_hit[s] = snoop_enable[s] && wo_write_valid && (wo_write_slot == 4'(s));
      assign sw_hit[s] = wr_commit && addr_in_bank && pstrb[0] && (addr_slot == 4'(s));
    end
  endgenerate

  // copies of the write-only registers
  generate
    for (genvar s = 0; s < SLOTS; s++) begin : g_shadow
      if (s == SLOT_CMOS_NMI) begin : g_cmos
        // a full port write carries the address too, so it beats a bare access
        always_comb begin
          next_shadow[s] = shadow[s];
          if (hw_hit[s]) begin
            next_shadow[s] = wo_write_data; // R09
          end else if (snoop_enable[s] && cmos_access_valid) begin
            next_shadow[s][`WOSB_CMOS_ADDR_MSB:0] = cmos_access_addr; // R09
          end else if (sw_hit[s]) begin
            next_shadow[s] = pwdata[7:0]; // R18
          end
        end
      end else begin : g_plain
        // hardware copy wins a same-cycle clash with software
        always_comb begin
          next_shadow[s] = shadow[s];
          if (hw_hit[s]) begin
            next_shadow[s] = wo_write_data; // R01 R18
          end else if (sw_hit[s]) begin
            next_shadow[s] = pwdata[7:0]; // R18
          end
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          shadow[s] <= `WOSB_SHADOW_RESET;
        end else begin
          shadow[s] <= next_shadow[s];
        end
      end
    end
  endgenerate

  // software may freeze a copy while it edits it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snoop_enable <= `WOSB_SNOOP_ENABLE_RESET;
    end else if (wr_commit && addr_is_enable) begin
      if (pstrb[0]) begin
        snoop_enable[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        snoop_enable[15:8] <= pwdata[15:8];
      end
    end
  end

  // sticky update flags, write one to clear, set wins over clear
  always_comb begin
    next_flags = update_flags;
    if (wr_commit && addr_is_flags) begin
      if (pstrb[0]) begin
        next_flags[7:0] = next_flags[7:0] & ~pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_flags[15:8] = next_flags[15:8] & ~pwdata[15:8];
      end
    end
    next_flags[SLOT_CMOS_NMI] = next_flags[SLOT_CMOS_NMI] || (snoop_enable[SLOT_CMOS_NMI] && cmos_access_valid);
    next_flags = next_flags | hw_hit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      update_flags <= `WOSB_FLAGS_RESET;
    end else begin
      update_flags <= next_flags;
    end
  end

endmodule : wosb_bank

/* rtl/wosb_defines.svh */
`ifndef WOSB_DEFINES_SVH
`define WOSB_DEFINES_SVH

// register indices; byte address is four times the index
`define WOSB_IDX_FIRST_DMA_REQ 8'h80
`define WOSB_IDX_FIRST_DMA_MASK 8'h81
`define WOSB_IDX_FIRST_DMA_MODE 8'h82
`define WOSB_IDX_FIRST_DMA_BPTR 8'h83
`define WOSB_IDX_FIRST_DMA_MCLR 8'h84
`define WOSB_IDX_FIRST_DMA_MSKCLR 8'h85
`define WOSB_IDX_TIMER_CMD 8'h86
`define WOSB_IDX_CMOS_NMI 8'h87
`define WOSB_IDX_SECOND_DMA_REQ 8'h88
`define WOSB_IDX_SECOND_DMA_MASK 8'h89
`define WOSB_IDX_SECOND_DMA_MODE 8'h8A
`define WOSB_IDX_SECOND_DMA_BPTR 8'h8B
`define WOSB_IDX_SECOND_DMA_MSKCLR 8'h8C
`define WOSB_IDX_SECOND_DMA_CLR 8'h8D
`define WOSB_IDX_COPROC_ERR 8'h8E
`define WOSB_IDX_EXT_CMOS_ADDR 8'h8F
`define WOSB_IDX_SNOOP_ENABLE 8'hA0
`define WOSB_IDX_UPDATE_FLAGS 8'hA1

// index field inside the byte address
`define WOSB_IDX_LSB 2
`define WOSB_IDX_MSB 9
`define WOSB_BANK_NIBBLE 4'h8
`define WOSB_SLOT_COUNT 16

// fields of the combined cmos address / nmi copy
`define WOSB_NMI_BIT 7
`define WOSB_CMOS_ADDR_MSB 6

`define WOSB_SHADOW_RESET 8'h00
`define WOSB_SNOOP_ENABLE_RESET 16'hFFFF
`define WOSB_FLAGS_RESET 16'h0000
`define WOSB_ZERO_WORD 32'h0000_0000

`endif

/* rtl/wosb_pkg.sv */
package wosb_pkg;

  typedef enum logic [1:0] {
    WOSB_ST_IDLE = 2'b00,
    WOSB_ST_DONE = 2'b01
  } wosb_state_t;

  typedef logic [7:0] wosb_byte_t;
  typedef logic [3:0] wosb_slot_t;

endpackage : wosb_pkg

/* tb/wosb_bank_sva.sv */
`timescale 1ns/100ps
module wosb_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc = psel && penable && !pready;
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");
  property p_ready_after; acc |=> pready; endproperty
  a_ready_after: assert property (p_ready_after) else $error("no answer one cycle after access");
  property p_ready_cause; $rose(pready) |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr outside answer");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
  property p_upper_zero; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_bad_addr; acc && (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != 0) |=> pslverr; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address accepted");
  property p_bank_ok;
    acc && paddr[9:6] == 4'h8 && paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == 0 |=> pready && !pslverr;
  endproperty
  a_bank_ok: assert property (p_bank_ok) else $error("shadow index refused");
  c_err: cover property (pready && pslverr);
  c_ok: cover property (pready && !pslverr);
  c_b2b: cover property (pready ##2 pready);
endmodule : wosb_checker

bind wosb_bank wosb_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* tb/wosb_bank_tb.sv */
`timescale 1ns/100ps
module wosb_bank_tb;
  import wosb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF, wo_write_slot = 4'h0;
  logic wo_write_valid = 1'b0, cmos_access_valid = 1'b0, er;
  logic [7:0] wo_write_data = 8'h00;
  logic [6:0] cmos_access_addr = 7'h00;
  int err_total = 0, samples_checked = 0;
  wosb_bank #(.ADDR_W(12)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wo_write_valid(wo_write_valid), .wo_write_slot(wo_write_slot), .wo_write_data(wo_write_data),
    .cmos_access_valid(cmos_access_valid), .cmos_access_addr(cmos_access_addr));
  initial forever #25 clk = ~clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk
  // master holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic snoop(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    wo_write_valid <= 1'b1; wo_write_slot <= s; wo_write_data <= d;
    @(posedge clk);
    wo_write_valid <= 1'b0;
  endtask : snoop
  task automatic t_reset;
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h200 + 12'(4 * i), 32'h0000_0000, 4'hF);
      chk("reset copy", {31'h0000_0000, 1'b0}, {rd[31:0]});
      chk("reset err", 32'h0000_0000, {31'h0000_0000, er});
    end
    apb(1'b0, 12'h280, 32'h0000_0000, 4'hF);
    chk("reset enable", 32'h0000_FFFF, rd);
    apb(1'b0, 12'h284, 32'h0000_0000, 4'hF);
    chk("reset flags", 32'h0000_0000, rd);
    $display("test reset done");
  endtask : t_reset
  task automatic t_snoop;
    for (int i = 0; i < 16; i++) snoop(4'(i), 8'h5A ^ 8'(i * 17));
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h200 + 12'(4 * i), 32'h0000_0000, 4'hF);
      chk("shadow copy", {24'h000000, 8'h5A ^ 8'(i * 17)}, rd);
    end
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_direct;
    logic [31:0] v;
    apb(1'b0, 12'h20C, 32'h0000_0000, 4'hF);
    chk("copy before edit", 32'h0000_0069, rd);
    v = 32'h0000_0063;
    apb(1'b1, 12'h20C, v, 4'hF);
    apb(1'b0, 12'h20C, 32'h0000_0000, 4'hF);
    chk("masked copy", v, rd);
    // lane 0 off must leave the copy alone
    apb(1'b1, 12'h20C, 32'h0000_00EE, 4'hE);
    apb(1'b0, 12'h20C, 32'h0000_0000, 4'hF);
    chk("strobe off copy", v, rd);
    $display("test direct done");
  endtask : t_direct
  task automatic t_cmos;
    snoop(4'h7, 8'h92);
    @(posedge clk);
    cmos_access_valid <= 1'b1; cmos_access_addr <= 7'h2B;
    @(posedge clk);
    cmos_access_valid <= 1'b0;
    apb(1'b0, 12'h21C, 32'h0000_0000, 4'hF);
    chk("nmi and cmos copy", 32'h0000_00AB, rd);
    $display("test cmos done");
  endtask : t_cmos
  task automatic t_err;
    apb(1'b0, 12'h400, 32'h0000_0000, 4'hF);
    chk("high addr err", 32'h0000_0001, {31'h0000_0000, er});
    chk("high addr data", 32'h0000_0000, rd);
    apb(1'b1, 12'h201, 32'h0000_0077, 4'hF);
    chk("misaligned err", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b1, 12'h3FC, 32'h0000_0077, 4'hF);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b0, 12'h200, 32'h0000_0000, 4'hF);
    chk("copy after refusal", 32'h0000_005A, rd);
    $display("test error done");
  endtask : t_err
  task automatic t_ctrl;
    apb(1'b0, 12'h284, 32'h0000_0000, 4'hF);
    chk("update flags", 32'h0000_FFFF, rd);
    apb(1'b1, 12'h284, 32'h0000_FFFF, 4'hF);
    apb(1'b1, 12'h280, 32'h0000_FFFE, 4'hF);
    snoop(4'h0, 8'h11);
    apb(1'b0, 12'h200, 32'h0000_0000, 4'hF);
    chk("frozen copy", 32'h0000_005A, rd);
    apb(1'b0, 12'h284, 32'h0000_0000, 4'hF);
    chk("flags after clear", 32'h0000_0000, rd);
    apb(1'b1, 12'h280, 32'h0000_FFFF, 4'hF);
    snoop(4'h0, 8'h11);
    apb(1'b0, 12'h200, 32'h0000_0000, 4'hF);
    chk("live copy", 32'h0000_0011, rd);
    $display("test control done");
  endtask : t_ctrl
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // limit well above the roughly 250 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_snoop();
    t_direct();
    t_cmos();
    t_err();
    t_ctrl();
    end_of_test();
  end
endmodule : wosb_bank_tb
